// ---- design/pcb_bridge_cfg.sv ----
// Function
// - bit 26 of bridge control enables posting
// - posting off: drain buffer before new data
// - posting off: next word after target accepts
// - posting off: hold master until last accepted
// - subsystem_identity, low half, read/write
// - subsystem device id, high half, read/write
// - lock bit blocks subsystem id writes
// - base register low bits read 01
// - decode operation window only when base nonzero
// - capability id reads 01
// - next capability pointer reads zero
// - power management revision reads 001
// - advertise PME from all states, D1/D2
`timescale 1ns/1ps
`default_nettype none

module pcb_bridge_cfg #(
   parameter int DATA_W    = pcb_pkg::DATA_W,
   parameter int BUF_DEPTH = pcb_pkg::BUF_DEPTH
) (
   // clock and reset
   input  wire logic                 clock,
   input  wire logic                 arst_n,
   // configuration access
   input  wire pcb_pkg::pcb_cfg_req_t cfg_req,
   output var  logic [DATA_W-1:0]    cfg_rdata,
   output var  logic                 cfg_ack,
   // i/o decode of operation window
   input  wire logic                 io_req,
   input  wire logic [31:0]          io_addr,
   output var  logic                 io_claim,
   output var  logic                 io_refuse,
   // source master write side
   input  wire logic                 src_valid,
   input  wire pcb_pkg::pcb_word_t   src_word,
   output var  logic                 src_ready,
   output var  logic                 src_done,
   // socket target side
   output var  logic                 tgt_valid,
   output var  pcb_pkg::pcb_word_t   tgt_word,
   input  wire logic                 tgt_ready,
   // status
   output var  logic                 posting_on
);

   localparam int WW = $bits(pcb_pkg::pcb_word_t);
   localparam int CW = $clog2(BUF_DEPTH + 1);

   ////////////////////////////////////////////////////////////////////////////////////////
   // reset release
   logic rst_meta_reg;
   logic rst_n;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_reg <= 1'b0;
         rst_n        <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n        <= rst_meta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // register storage
   logic        post_en_reg;
   logic        id_lock_reg;
   logic [31:0] subsys_id_reg;
   logic [29:0] base_reg;
   logic        cfg_wr;
   logic        cfg_rd;

   assign cfg_wr = cfg_req.req && cfg_req.we;
   assign cfg_rd = cfg_req.req && !cfg_req.we;

   function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  be);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return res;
   endfunction : merge_be

   logic [31:0] bridge_word;
   logic [31:0] lock_word;
   logic [31:0] base_word;
   logic [31:0] bridge_merged;
   logic [31:0] lock_merged;
   logic [31:0] base_merged;

   always_comb begin
      bridge_word = '0;
      bridge_word[pcb_pkg::POST_EN_BIT] = post_en_reg;
      lock_word = '0;
      lock_word[pcb_pkg::ID_LOCK_BIT] = id_lock_reg;
      base_word = {base_reg, pcb_pkg::IO_SPACE_IND};
   end

   assign bridge_merged = merge_be(bridge_word, cfg_req.wdata, cfg_req.be);
   assign lock_merged   = merge_be(lock_word, cfg_req.wdata, cfg_req.be);
   assign base_merged   = merge_be(base_word, cfg_req.wdata, cfg_req.be);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         post_en_reg <= pcb_pkg::RST_POST_EN;
      end else if (cfg_wr && cfg_req.addr == pcb_pkg::OFF_BRIDGE_CTRL) begin
         post_en_reg <= bridge_merged[pcb_pkg::POST_EN_BIT];
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         id_lock_reg <= pcb_pkg::RST_ID_LOCK;
      end else if (cfg_wr && cfg_req.addr == pcb_pkg::OFF_ID_LOCK) begin
         id_lock_reg <= lock_merged[pcb_pkg::ID_LOCK_BIT];
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         subsys_id_reg <= pcb_pkg::RST_SUBSYS_ID;
      end else if (cfg_wr && cfg_req.addr == pcb_pkg::OFF_SUBSYS_ID && !id_lock_reg) begin
         subsys_id_reg <= merge_be(subsys_id_reg, cfg_req.wdata, cfg_req.be);
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         base_reg <= pcb_pkg::RST_BASE;
      end else if (cfg_wr && cfg_req.addr == pcb_pkg::OFF_LEGACY_BASE) begin
         base_reg <= base_merged[31:pcb_pkg::BASE_LSB];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // read mux, one cycle answer
   logic [31:0] rd_val;

   always_comb begin
      rd_val = '0;
      case (cfg_req.addr)
         pcb_pkg::OFF_BRIDGE_CTRL: rd_val = bridge_word;
         pcb_pkg::OFF_SUBSYS_ID:   rd_val = subsys_id_reg;
         pcb_pkg::OFF_LEGACY_BASE: rd_val = base_word;
         pcb_pkg::OFF_PM_CAP:      rd_val = pcb_pkg::PM_CAP_VAL;
         pcb_pkg::OFF_ID_LOCK:     rd_val = lock_word;
         default:                  rd_val = '0;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cfg_ack   <= 1'b0;
         cfg_rdata <= '0;
      end else begin
         cfg_ack   <= cfg_req.req;
         cfg_rdata <= cfg_rd ? rd_val : '0;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         posting_on <= pcb_pkg::RST_POST_EN;
      end else begin
         posting_on <= post_en_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // operation window decode
   logic base_set;

   assign base_set = (base_reg != '0);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         io_claim  <= 1'b0;
         io_refuse <= 1'b0;
      end else begin
         io_claim  <= io_req && base_set && (io_addr[31:pcb_pkg::BASE_LSB] == base_reg);
         io_refuse <= io_req && !base_set;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // write forwarding path
   logic                  buf_in_ready;
   logic                  buf_out_valid;
   logic [WW-1:0]         buf_out_data;
   logic                  push;
   logic                  pop;
   logic [CW-1:0]         held_reg;
   logic [CW-1:0]         held_next;
   pcb_pkg::pcb_wp_state_t state_reg;
   logic                  txn_post_reg;
   logic                  ready_next;

   assign push = src_valid && src_ready && buf_in_ready;
   assign pop  = buf_out_valid && tgt_ready;

   pcb_word_buf #(
      .WIDTH (WW),
      .DEPTH (BUF_DEPTH)
   ) u_buf (
      .clock     (clock),
      .rst_n     (rst_n),
      .in_valid  (src_valid && src_ready),
      .in_data   (src_word),
      .in_ready  (buf_in_ready),
      .out_valid (buf_out_valid),
      .out_data  (buf_out_data),
      .out_ready (tgt_ready)
   );

   assign tgt_valid = buf_out_valid;
   assign tgt_word  = buf_out_data;

   // words taken from the source and not yet accepted by the target
   always_comb begin
      held_next = held_reg;
      if (push && !pop) begin
         held_next = held_reg + CW'(1);
      end else if (pop && !push) begin
         held_next = held_reg - CW'(1);
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         held_reg <= '0;
      end else begin
         held_reg <= held_next;
      end
   end

   // transaction sequencing
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_reg    <= pcb_pkg::WP_IDLE;
         txn_post_reg <= pcb_pkg::RST_POST_EN;
         src_done     <= 1'b0;
      end else begin
         src_done <= 1'b0;
         case (state_reg)
            pcb_pkg::WP_IDLE: begin
               txn_post_reg <= post_en_reg;
               if (push) begin
                  if (src_word.last && post_en_reg) begin
                     src_done <= 1'b1;
                  end else if (src_word.last) begin
                     state_reg <= pcb_pkg::WP_HOLD;
                  end else begin
                     state_reg <= pcb_pkg::WP_BURST;
                  end
               end
            end
            pcb_pkg::WP_BURST: begin
               if (push && src_word.last) begin
                  if (txn_post_reg) begin
                     src_done  <= 1'b1;
                     state_reg <= pcb_pkg::WP_IDLE;
                  end else begin
                     state_reg <= pcb_pkg::WP_HOLD;
                  end
               end
            end
            pcb_pkg::WP_HOLD: begin
               if (pop && buf_out_data[0]) begin
                  src_done  <= 1'b1;
                  state_reg <= pcb_pkg::WP_IDLE;
               end
            end
            default: begin
               state_reg <= pcb_pkg::WP_IDLE;
            end
         endcase
      end
   end

   // source ready for the next cycle
   always_comb begin
      ready_next = 1'b0;
      if (state_reg == pcb_pkg::WP_HOLD) begin
         ready_next = 1'b0;
      end else if (push && src_word.last && !txn_post_reg && state_reg == pcb_pkg::WP_BURST) begin
         ready_next = 1'b0;
      end else if (push && src_word.last && !post_en_reg && state_reg == pcb_pkg::WP_IDLE) begin
         ready_next = 1'b0;
      end else if (state_reg == pcb_pkg::WP_IDLE && !post_en_reg) begin
         ready_next = (held_next == '0);
      end else if (state_reg == pcb_pkg::WP_BURST && !txn_post_reg) begin
         ready_next = (held_next == '0);
      end else begin
         ready_next = (held_next < CW'(BUF_DEPTH));
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         src_ready <= 1'b0;
      end else begin
         src_ready <= ready_next;
      end
   end

endmodule : pcb_bridge_cfg

`default_nettype wire

// ---- design/pcb_pkg.sv ----
package pcb_pkg;

   ////////////////////////////////////////////////////////////////////////////////////////
   // widths and buffer shape
   localparam int DATA_W    = 32;
   localparam int ADDR_W    = 8;
   localparam int BUF_DEPTH = 2;

   ////////////////////////////////////////////////////////////////////////////////////////
   // configuration offsets (byte addresses)
   localparam logic [ADDR_W-1:0] OFF_BRIDGE_CTRL = 8'h3c;
   localparam logic [ADDR_W-1:0] OFF_SUBSYS_ID   = 8'h40;
   localparam logic [ADDR_W-1:0] OFF_LEGACY_BASE = 8'h44;
   localparam logic [ADDR_W-1:0] OFF_PM_CAP      = 8'h80;
   localparam logic [ADDR_W-1:0] OFF_ID_LOCK     = 8'h98;

   ////////////////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int POST_EN_BIT  = 26;
   localparam int ID_LOCK_BIT  = 0;
   localparam int SVID_LSB     = 0;
   localparam int SDID_LSB     = 16;
   localparam int BASE_LSB     = 2;

   ////////////////////////////////////////////////////////////////////////////////////////
   // values after reset
   localparam logic        RST_POST_EN   = 1'h0;
   localparam logic        RST_ID_LOCK   = 1'h0;
   localparam logic [31:0] RST_SUBSYS_ID = 32'h00000000;
   localparam logic [29:0] RST_BASE      = 30'h00000000;
   localparam logic [1:0]  IO_SPACE_IND  = 2'h1;

   ////////////////////////////////////////////////////////////////////////////////////////
   // power management capability header, read only
   localparam logic [7:0]  PM_CAP_ID     = 8'h01;
   localparam logic [7:0]  PM_NEXT_PTR   = 8'h00;
   localparam logic [2:0]  PM_REVISION   = 3'h1;
   localparam logic        PM_CLOCK      = 1'h0;
   localparam logic        PM_AUX_POWER  = 1'h1;
   localparam logic        PM_DEV_INIT   = 1'h0;
   localparam logic [1:0]  PM_RSVD       = 2'h0;
   localparam logic        PM_DYN_DATA   = 1'h0;
   localparam logic        PM_D1_SUP     = 1'h1;
   localparam logic        PM_D2_SUP     = 1'h1;
   localparam logic [4:0]  PM_PME_FROM   = 5'h1f;
   localparam logic [31:0] PM_CAP_VAL    = {PM_PME_FROM, PM_D2_SUP, PM_D1_SUP, PM_DYN_DATA,
                                            PM_RSVD, PM_DEV_INIT, PM_AUX_POWER, PM_CLOCK,
                                            PM_REVISION, PM_NEXT_PTR, PM_CAP_ID};

   ////////////////////////////////////////////////////////////////////////////////////////
   // carriers
   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic              last;
   } pcb_word_t;

   typedef struct packed {
      logic              req;
      logic              we;
      logic [ADDR_W-1:0] addr;
      logic [3:0]        be;
      logic [DATA_W-1:0] wdata;
   } pcb_cfg_req_t;

   typedef enum logic [1:0] {
      WP_IDLE,
      WP_BURST,
      WP_HOLD
   } pcb_wp_state_t;

endpackage : pcb_pkg

// ---- design/pcb_word_buf.sv ----
`timescale 1ns/1ps
`default_nettype none

module pcb_word_buf #(
   parameter int WIDTH = 33,
   parameter int DEPTH = 2
) (
   // clock and reset
   input  wire logic             clock,
   input  wire logic             rst_n,
   // fill side
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output var  logic             in_ready,
   // drain side
   output var  logic             out_valid,
   output var  logic [WIDTH-1:0] out_data,
   input  wire logic             out_ready
);

   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [CW-1:0]    cnt_reg;
   logic [CW-1:0]    cnt_next;
   logic             push;
   logic             pop;

   assign push     = in_valid && in_ready;
   assign pop      = out_valid && out_ready;
   assign out_data = mem_reg[0];

   always_comb begin
      cnt_next = cnt_reg;
      if (push && !pop) begin
         cnt_next = cnt_reg + CW'(1);
      end else if (pop && !push) begin
         cnt_next = cnt_reg - CW'(1);
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg   <= '0;
         out_valid <= 1'b0;
         in_ready  <= 1'b0;
      end else begin
         cnt_reg   <= cnt_next;
         out_valid <= (cnt_next != '0);
         in_ready  <= (cnt_next < CW'(DEPTH));
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // head at entry 0, shift toward it on each pop
   for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      logic [WIDTH-1:0] above;
      if (i < DEPTH - 1) begin : g_up
         assign above = mem_reg[i+1];
      end else begin : g_top
         assign above = mem_reg[i];
      end
      always_ff @(posedge clock or negedge rst_n) begin
         if (!rst_n) begin
            mem_reg[i] <= '0;
         end else if (pop) begin
            if (push && (cnt_reg == CW'(i + 1))) begin
               mem_reg[i] <= in_data;
            end else begin
               mem_reg[i] <= above;
            end
         end else if (push && (cnt_reg == CW'(i))) begin
            mem_reg[i] <= in_data;
         end
      end
   end

endmodule : pcb_word_buf

`default_nettype wire

// ---- testbench/pcb_bridge_cfg_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none

module pcb_bridge_cfg_asserts #(
   parameter int DATA_W    = pcb_pkg::DATA_W,
   parameter int BUF_DEPTH = pcb_pkg::BUF_DEPTH
) (
   // clock and reset
   input wire logic                  clock,
   input wire logic                  arst_n,
   // config access
   input wire pcb_pkg::pcb_cfg_req_t cfg_req,
   input wire logic [DATA_W-1:0]     cfg_rdata,
   input wire logic                  cfg_ack,
   // operation window
   input wire logic                  io_req,
   input wire logic                  io_claim,
   input wire logic                  io_refuse,
   // write path
   input wire logic                  src_valid,
   input wire pcb_pkg::pcb_word_t    src_word,
   input wire logic                  src_ready,
   input wire logic                  src_done,
   input wire logic                  tgt_valid,
   input wire pcb_pkg::pcb_word_t    tgt_word,
   input wire logic                  tgt_ready,
   input wire logic                  posting_on
);

   default clocking @(posedge clock);
   endclocking
   default disable iff (!arst_n);

   ////////////////////////////////////////////////////////////////////////////////////////
   // config and window answers
   a_ack_one_cycle: assert property (cfg_ack == $past(cfg_req.req))
      else $error("config ack not one cycle after request");
   a_base_low_bits: assert property (
      $past(cfg_req.req && !cfg_req.we && cfg_req.addr == 8'h44) |-> cfg_rdata[1:0] == 2'h1)
      else $error("base low bits not 01");
   a_cap_header_val: assert property (
      $past(cfg_req.req && !cfg_req.we && cfg_req.addr == 8'h80)
      |-> cfg_rdata[18:0] == 19'h10001 && cfg_rdata[31:25] == 7'h7f)
      else $error("capability header wrong");
   a_io_one_answer: assert property (
      (io_claim || io_refuse) |-> $past(io_req) && !(io_claim && io_refuse))
      else $error("window answer without request");

   ////////////////////////////////////////////////////////////////////////////////////////
   // write path
   a_drain_first: assert property (!posting_on && tgt_valid |-> !src_ready)
      else $error("word taken while buffer not empty");
   a_single_take: assert property (!posting_on && src_valid && src_ready |=> !src_ready)
      else $error("second word taken before target accepted");
   a_hold_master: assert property (
      !posting_on && src_done |-> $past(tgt_valid && tgt_ready && tgt_word.last))
      else $error("master released before last word accepted");
   a_post_release: assert property (
      posting_on && src_valid && src_ready && src_word.last |=> src_done)
      else $error("posted write not completed");
   a_word_stable: assert property (
      tgt_valid && !tgt_ready |=> tgt_valid && $stable(tgt_word))
      else $error("stalled word lost or changed");

endmodule : pcb_bridge_cfg_asserts

bind pcb_bridge_cfg pcb_bridge_cfg_asserts #(.DATA_W(DATA_W), .BUF_DEPTH(BUF_DEPTH)) u_chk (
   .clock      (clock),
   .arst_n     (arst_n),
   .cfg_req    (cfg_req),
   .cfg_rdata  (cfg_rdata),
   .cfg_ack    (cfg_ack),
   .io_req     (io_req),
   .io_claim   (io_claim),
   .io_refuse  (io_refuse),
   .src_valid  (src_valid),
   .src_word   (src_word),
   .src_ready  (src_ready),
   .src_done   (src_done),
   .tgt_valid  (tgt_valid),
   .tgt_word   (tgt_word),
   .tgt_ready  (tgt_ready),
   .posting_on (posting_on)
);

`default_nettype wire

// ---- testbench/pcb_tgt_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module pcb_tgt_model (
   // clock
   input  wire logic clock,
   // stall control
   input  wire logic slow,
   // acceptance
   output var  logic tgt_ready
);
   int seed = 32'hb337;

   // socket target: random acceptance, rare when slow
   initial tgt_ready = 1'b0;
   always @(posedge clock) begin
      tgt_ready <= slow ? (($random(seed) & 3) == 0) : (($random(seed) & 3) != 3);
   end
endmodule : pcb_tgt_model

`default_nettype wire

// ---- testbench/tb_pcb_bridge_cfg.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_pcb_bridge_cfg;
   logic                  clock     = 1'b0;
   logic                  arst_n    = 1'b0;
   pcb_pkg::pcb_cfg_req_t cfg_req   = '0;
   logic [31:0]           cfg_rdata;
   logic                  cfg_ack;
   logic                  io_req    = 1'b0;
   logic [31:0]           io_addr   = '0;
   logic                  io_claim;
   logic                  io_refuse;
   logic                  src_valid = 1'b0;
   pcb_pkg::pcb_word_t    src_word  = '0;
   logic                  src_ready;
   logic                  src_done;
   logic                  tgt_valid;
   pcb_pkg::pcb_word_t    tgt_word;
   logic                  tgt_ready;
   logic                  posting_on;
   logic                  slow      = 1'b0;
   logic [31:0]           eq[$];
   logic [32:0]           wq[$];
   int                    seed      = 32'hb337;
   int                    errors    = 0;
   int                    num_checks = 0;
   int                    dones     = 0;
   int                    cyc       = 0;
   logic [31:0]           d;

   always #10 clock = ~clock;

   pcb_bridge_cfg dut (.clock(clock), .arst_n(arst_n), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
      .cfg_ack(cfg_ack), .io_req(io_req), .io_addr(io_addr), .io_claim(io_claim),
      .io_refuse(io_refuse), .src_valid(src_valid), .src_word(src_word), .src_ready(src_ready),
      .src_done(src_done), .tgt_valid(tgt_valid), .tgt_word(tgt_word), .tgt_ready(tgt_ready),
      .posting_on(posting_on));

   pcb_tgt_model tgt (.clock(clock), .slow(slow), .tgt_ready(tgt_ready));

   ////////////////////////////////////////////////////////////////////////////////////////
   // compare and close
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic give_verdict();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : give_verdict

   ////////////////////////////////////////////////////////////////////////////////////////
   // drivers
   task automatic cfg(input logic we, input logic [7:0] a, input logic [31:0] wd,
                      input logic [3:0] be, input logic [31:0] exp);
      @(posedge clock);
      cfg_req <= {1'b1, we, a, be, wd};
      eq.push_back(exp);
      @(posedge clock);
      cfg_req.req <= 1'b0;
   endtask : cfg

   task automatic io(input logic [31:0] a, input logic [1:0] exp);
      @(posedge clock);
      io_req  <= 1'b1;
      io_addr <= a;
      @(posedge clock);
      io_req <= 1'b0;
      @(negedge clock);
      check(33'({io_claim, io_refuse}), 33'(exp));
   endtask : io

   task automatic send(input int n);
      logic [32:0] w;
      int          k;
      int          d0;
      d0 = dones;
      @(posedge clock);
      for (int i = 0; i < n; i++) begin
         w = {32'($random(seed)), i == n - 1};
         src_valid <= 1'b1;
         src_word  <= w;
         wq.push_back(w);
         k = 0;
         do begin
            @(posedge clock);
            k++;
         end while (src_ready !== 1'b1 && k < 100);
         if (src_ready !== 1'b1)
            errors++;
      end
      src_valid <= 1'b0;
      k = 0;
      while (dones == d0 && k < 100) begin
         @(posedge clock);
         k++;
      end
      if (dones == d0)
         errors++;
   endtask : send

   ////////////////////////////////////////////////////////////////////////////////////////
   // watchers
   always @(posedge clock) begin
      if (cfg_ack === 1'b1)
         check(33'(cfg_rdata), 33'(eq.pop_front()));
      if (tgt_valid === 1'b1 && tgt_ready === 1'b1)
         check(tgt_word, wq.pop_front());
      if (src_done === 1'b1)
         dones++;
      cyc++;
      if (cyc == 5000) begin
         errors++;
         give_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (4) @(posedge clock);
      arst_n <= 1'b1;
      repeat (3) @(posedge clock);
      check(33'(posting_on), 33'd0);
      cfg(1'b0, 8'h40, 32'h0, 4'hf, 32'h00000000);
      cfg(1'b0, 8'h44, 32'h0, 4'hf, 32'h00000001);
      cfg(1'b0, 8'h80, 32'h0, 4'hf, 32'hfe110001);
      cfg(1'b0, 8'h98, 32'h0, 4'hf, 32'h00000000);
      cfg(1'b0, 8'h10, 32'h0, 4'hf, 32'h00000000);
      io(32'h000003e0, 2'b01);
      cfg(1'b1, 8'h40, 32'h1234abcd, 4'h3, 32'h0);
      cfg(1'b0, 8'h40, 32'h0, 4'hf, 32'h0000abcd);
      cfg(1'b1, 8'h40, 32'h5678ffff, 4'hc, 32'h0);
      cfg(1'b0, 8'h40, 32'h0, 4'hf, 32'h5678abcd);
      cfg(1'b1, 8'h98, 32'h1, 4'hf, 32'h0);
      cfg(1'b1, 8'h40, 32'h0, 4'hf, 32'h0);
      cfg(1'b0, 8'h40, 32'h0, 4'hf, 32'h5678abcd);
      cfg(1'b1, 8'h98, 32'h0, 4'hf, 32'h0);
      d = $random(seed);
      cfg(1'b1, 8'h40, d, 4'hf, 32'h0);
      cfg(1'b0, 8'h40, 32'h0, 4'hf, d);
      cfg(1'b1, 8'h44, 32'h000003e2, 4'hf, 32'h0);
      cfg(1'b0, 8'h44, 32'h0, 4'hf, 32'h000003e1);
      cfg(1'b1, 8'h44, 32'h000003e1, 4'hf, 32'h0);
      cfg(1'b0, 8'h44, 32'h0, 4'hf, 32'h000003e1);
      io(32'h000003e0, 2'b10);
      io(32'h000003e4, 2'b00);
      cfg(1'b1, 8'h80, 32'h0, 4'hf, 32'h0);
      cfg(1'b0, 8'h80, 32'h0, 4'hf, 32'hfe110001);
      // posting off, quick then stalling target
      send(1);
      slow <= 1'b1;
      send(4);
      slow <= 1'b0;
      cfg(1'b1, 8'h3c, 32'hffffffff, 4'hf, 32'h0);
      cfg(1'b0, 8'h3c, 32'h0, 4'hf, 32'h04000000);
      repeat (2) @(posedge clock);
      check(33'(posting_on), 33'd1);
      // posting on, buffer filled by a stalling target
      slow <= 1'b1;
      send(6);
      slow <= 1'b0;
      send(3);
      repeat (20) @(posedge clock);
      check(33'(dones), 33'd4);
      check(33'(wq.size()), 33'd0);
      check(33'(eq.size()), 33'd0);
      give_verdict();
   end
endmodule : tb_pcb_bridge_cfg

`default_nettype wire
